/* File: hw/pwmci_top.v */
// Multi-channel PWM block with init, de-init and set-duty commands
`timescale 1ns/100ps
`include "pwmci_defs.vh"
module pwmci_top #(
  parameter NCH = 4,                 // Number of channels
  parameter PW = 16,                 // Period counter width
  parameter CHW = 2,                 // Channel number width
  parameter DEINIT_SUPPORT = 1,      // deinit_support_option
  parameter SET_DUTY_SUPPORT = 1,    // set_duty_support_option
  parameter ERROR_CHECK = 1          // Double-init detection
) (
  input wire i_clock,                    // 40 MHz clock
  input wire i_rst,                      // Async reset, high
  input wire i_cmd_valid,                // Command strobe
  input wire [7:0] i_cmd_id,             // Command code
  input wire [CHW-1:0] i_cmd_channel,    // Set-duty channel
  input wire [15:0] i_cmd_duty,          // Set-duty value
  input wire [NCH-1:0] i_cfg_present,    // Channel is configured
  input wire [NCH*PW-1:0] i_cfg_period,  // Default periods
  input wire [NCH*16-1:0] i_cfg_duty,    // Default duties
  input wire [NCH-1:0] i_cfg_polarity,   // Active levels
  input wire [NCH-1:0] i_cfg_idle,       // Idle levels
  input wire [NCH*2-1:0] i_cfg_class,    // Channel classes
  input wire [NCH*PW-1:0] i_cfg_phase,   // Phase shift counts
  input wire [NCH*CHW-1:0] i_cfg_ref,    // Phase reference channel
  input wire i_phase_support,            // Hardware phase shift
  input wire i_end_update,               // duty_update_at_period_end
  input wire [NCH-1:0] i_notify_en_set,  // Software enables edges
  input wire [7:0] i_power_target,       // Requested power state
  output reg [NCH-1:0] o_pwm,            // Pulse outputs
  output reg o_initialised,              // Block initialised
  output reg o_err_double_init,          // Double-init error pulse
  output reg o_err_not_init,             // Command before init pulse
  output reg [NCH-1:0] o_notify_en,      // Edge notify enables
  output reg o_irq_en,                   // Interrupt enable
  output reg [NCH-1:0] o_edge_event,     // Enabled edge pulses
  output reg [7:0] o_power_state         // Active power state
);
  reg init_reg;
  reg [NCH-1:0] run_reg;
  reg [NCH-1:0] start_reg;
  reg [NCH-1:0] duty_wr_reg;
  reg [15:0] duty_val_reg;
  reg [NCH-1:0] pwm_prev_reg;
  reg [NCH-1:0] notify_next;
  wire [NCH-1:0] pwm_int;
  wire is_init;
  wire is_deinit;
  wire is_duty;
  wire duty_ok;
  assign is_init = i_cmd_valid && i_cmd_id == `PWMCI_CMD_INIT;
  assign is_deinit = i_cmd_valid && i_cmd_id == `PWMCI_CMD_DEINIT &&
                     DEINIT_SUPPORT != 0;
  assign is_duty = i_cmd_valid && i_cmd_id == `PWMCI_CMD_SET_DUTY &&
                   SET_DUTY_SUPPORT != 0;
  // Out-of-range duty is clipped to full scale
  assign duty_ok = i_cmd_duty <= `PWMCI_DUTY_FULL;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gch
      wire [CHW-1:0] refc;
      wire [PW-1:0] ph;
      assign refc = i_cfg_ref[g*CHW +: CHW];
      // Offset adds onto the reference channel's own phase
      assign ph = i_phase_support ?
        i_cfg_phase[g*PW +: PW] + i_cfg_phase[refc*PW +: PW] :
        {PW{1'b0}};
      pwmci_channel #(.PW(PW)) u_ch (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_run(run_reg[g]),
        .i_start(start_reg[g]),
        .i_def_period(i_cfg_period[g*PW +: PW]),
        .i_def_duty(i_cfg_duty[g*16 +: 16]),
        .i_phase(ph),
        .i_polarity(i_cfg_polarity[g]),
        .i_idle(i_cfg_idle[g]),
        .i_end_update(i_end_update),
        .i_duty_wr(duty_wr_reg[g]),
        .i_duty(duty_val_reg),
        .o_pwm(pwm_int[g])
      );
    end
  endgenerate

  always @* begin
    notify_next = o_notify_en | i_notify_en_set;
    if (is_init && !init_reg)
      notify_next = {NCH{1'b0}};
    if (is_deinit && init_reg)
      notify_next = {NCH{1'b0}};
  end

  integer k;
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      init_reg <= 1'b0;
      run_reg <= {NCH{1'b0}};
      start_reg <= {NCH{1'b0}};
      duty_wr_reg <= {NCH{1'b0}};
      duty_val_reg <= 16'h0000;
      o_err_double_init <= 1'b0;
      o_err_not_init <= 1'b0;
      o_notify_en <= {NCH{1'b0}};
      o_irq_en <= 1'b0;
      o_power_state <= `PWMCI_PWR_FULL;
    end else begin
      start_reg <= {NCH{1'b0}};
      duty_wr_reg <= {NCH{1'b0}};
      o_err_double_init <= 1'b0;
      o_err_not_init <= 1'b0;
      o_notify_en <= init_reg || is_init ? notify_next : {NCH{1'b0}};
      // Only full power exists; requests leave it there
      o_power_state <= `PWMCI_PWR_FULL;
      if (is_init) begin
        if (init_reg) begin
          o_err_double_init <= ERROR_CHECK != 0;
        end else begin
          init_reg <= 1'b1;
          o_irq_en <= 1'b1;
          start_reg <= i_cfg_present;
          run_reg <= i_cfg_present;
        end
      end else if (is_deinit) begin
        if (!init_reg) begin
          o_err_not_init <= 1'b1;
        end else begin
          init_reg <= 1'b0;
          run_reg <= {NCH{1'b0}};
          o_irq_en <= 1'b0;
        end
      end else if (is_duty) begin
        if (!init_reg) begin
          o_err_not_init <= 1'b1;
        end else begin
          // Every class accepts duty; period stays the configured one
          for (k = 0; k < NCH; k = k + 1)
            duty_wr_reg[k] <= run_reg[k] &&
                              i_cmd_channel == k[CHW-1:0];
          duty_val_reg <= duty_ok ? i_cmd_duty : `PWMCI_DUTY_FULL;
        end
      end
    end
  end

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pwm <= {NCH{1'b0}};
      pwm_prev_reg <= {NCH{1'b0}};
      o_edge_event <= {NCH{1'b0}};
      o_initialised <= 1'b0;
    end else begin
      o_pwm <= pwm_int;
      pwm_prev_reg <= pwm_int;
      o_edge_event <= (pwm_int ^ pwm_prev_reg) & o_notify_en;
      o_initialised <= init_reg;
    end
  end
endmodule

/* File: hw/pwmci_defs.vh */
// Constants for the multi-channel PWM block
`ifndef PWMCI_DEFS_VH
`define PWMCI_DEFS_VH
`define PWMCI_CMD_INIT 8'h00
`define PWMCI_CMD_DEINIT 8'h01
`define PWMCI_CMD_SET_DUTY 8'h02
`define PWMCI_DUTY_FULL 16'h8000
`define PWMCI_DUTY_ZERO 16'h0000
`define PWMCI_PWR_FULL 8'h00
`define PWMCI_CLASS_VARIABLE 2'h0
`define PWMCI_CLASS_FIXED 2'h1
`define PWMCI_CLASS_SHIFTED 2'h2
`endif

/* File: hw/pwmci_channel.v */
// One PWM channel: period counter, duty compare, deferred update
`timescale 1ns/100ps
`include "pwmci_defs.vh"
module pwmci_channel #(
  parameter PW = 16
) (
  input wire i_clock,              // System clock
  input wire i_rst,                // Async reset, high
  input wire i_run,                // Channel running
  input wire i_start,              // Load defaults, restart
  input wire [PW-1:0] i_def_period, // Default period
  input wire [15:0] i_def_duty,    // Default duty
  input wire [PW-1:0] i_phase,     // Start offset in counts
  input wire i_polarity,           // Active level
  input wire i_idle,               // Idle level
  input wire i_end_update,         // Defer duty to period end
  input wire i_duty_wr,            // Duty write strobe
  input wire [15:0] i_duty,        // New duty value
  output reg o_pwm                 // Pulse output
);
  reg [PW-1:0] cnt_reg;
  reg [15:0] duty_reg;
  reg [15:0] pend_reg;
  reg pend_valid_reg;
  reg [PW-1:0] hi_cnt_reg;
  reg [PW-1:0] cnt_next;
  reg [PW+16-1:0] prod;
  reg [PW-1:0] hi_next;
  reg level_next;
  wire period_end;
  wire [15:0] duty_use;
  assign period_end = (i_def_period == {PW{1'b0}}) ||
                      (cnt_reg == i_def_period - {{(PW-1){1'b0}}, 1'b1});
  assign duty_use = (pend_valid_reg && period_end) ? pend_reg : duty_reg;
  always @* begin
    cnt_next = period_end ? {PW{1'b0}} : cnt_reg + {{(PW-1){1'b0}}, 1'b1};
    // Linear share of the period, 0x8000 = full scale
    prod = i_def_period * duty_use;
    // Duty at or above full scale skips the compare, so the dropped top product bit is never used
    hi_next = prod[PW+14:15];
    if (i_def_period == {PW{1'b0}} || duty_use == `PWMCI_DUTY_ZERO)
      level_next = ~i_polarity;
    else if (duty_use >= `PWMCI_DUTY_FULL)
      level_next = i_polarity;
    else
      level_next = (cnt_next < hi_next) ? i_polarity : ~i_polarity;
  end
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= {PW{1'b0}};
      duty_reg <= 16'h0000;
      pend_reg <= 16'h0000;
      pend_valid_reg <= 1'b0;
      hi_cnt_reg <= {PW{1'b0}};
      o_pwm <= 1'b0;
    end else if (i_start) begin
      cnt_reg <= i_phase;
      duty_reg <= i_def_duty;
      pend_valid_reg <= 1'b0;
      o_pwm <= ~i_polarity;
    end else if (!i_run) begin
      o_pwm <= i_idle;
      pend_valid_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hi_cnt_reg <= hi_next;
      // Output follows the counter compare; only with i_end_update set is a duty change held to period end, so no runt pulse
      o_pwm <= level_next;
      if (i_duty_wr && i_end_update) begin
        pend_reg <= i_duty;
        pend_valid_reg <= 1'b1;
      end else if (i_duty_wr) begin
        duty_reg <= i_duty;
        pend_valid_reg <= 1'b0;
      end else if (pend_valid_reg && period_end) begin
        duty_reg <= pend_reg;
        pend_valid_reg <= 1'b0;
      end
    end
  end
endmodule

/* File: tb/pwmci_props.sv */
// Port checker for the PWM command block
`timescale 1ns/100ps
module pwmci_props #(
  parameter NCH = 4
) (
  input wire i_clock, // Clock
  input wire i_rst, // Reset
  input wire i_cmd_valid, // Strobe
  input wire [7:0] i_cmd_id, // Code
  input wire [NCH-1:0] i_cfg_present, // Configured
  input wire [NCH-1:0] i_cfg_idle, // Idle levels
  input wire [NCH-1:0] o_pwm, // Outputs
  input wire o_initialised, // Ready
  input wire o_err_double_init, // Error
  input wire o_err_not_init, // Error
  input wire [NCH-1:0] o_notify_en, // Enables
  input wire [NCH-1:0] o_edge_event, // Edge pulses
  input wire o_irq_en, // Irq enable
  input wire [7:0] o_power_state // Power
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire init_c = i_cmd_valid && i_cmd_id == 8'h00;
  wire other_c = i_cmd_valid && (i_cmd_id == 8'h01 || i_cmd_id == 8'h02);
  wire ini = init_c && !o_initialised;
  wire dbl = init_c && o_initialised;
  wire dei = i_cmd_valid && i_cmd_id == 8'h01 && o_initialised;
  property p_init; ini |-> ##2 o_initialised; endproperty
  a_init: assert property (p_init) else $error("init not taken");
  property p_clr; ini |-> ##2 o_notify_en == '0; endproperty
  a_clr: assert property (p_clr) else $error("enables kept");
  property p_dbl; dbl |=> o_err_double_init; endproperty
  a_dbl: assert property (p_dbl) else $error("no double error");
  property p_keep; dbl |-> o_initialised [*3]; endproperty
  a_keep: assert property (p_keep) else $error("double acted");
  property p_nini; other_c && !o_initialised |=> o_err_not_init; endproperty
  a_nini: assert property (p_nini) else $error("no early error");
  property p_off;
    dei |-> ##2 !o_initialised && !o_irq_en && o_notify_en == '0;
  endproperty
  a_off: assert property (p_off) else $error("still enabled");
  property p_idle;
    dei |-> ##3 ((o_pwm ^ i_cfg_idle) & i_cfg_present) == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("not idle");
  property p_pwr; o_power_state == 8'h00; endproperty
  a_pwr: assert property (p_pwr) else $error("power state");
  property p_evt; (o_edge_event & ~$past(o_notify_en)) == '0; endproperty
  a_evt: assert property (p_evt) else $error("edge not enabled");
  c_init: cover property (ini);
  c_dbl: cover property (dbl);
  c_dei: cover property (dei);
  c_evt: cover property (o_edge_event != '0);
endmodule
bind pwmci_top pwmci_props #(.NCH(NCH)) pwmci_props_i (.*);

/* File: tb/pwmci_load.sv */
// Load model: counts active cycles and entries to active
`timescale 1ns/100ps
module pwmci_load (
  input wire i_clock, // Clock
  input wire i_line, // Observed output
  input wire i_active, // Active level
  input wire i_start, // Open a window
  input wire [15:0] i_len, // Window length
  output logic o_done, // Window closed
  output logic [15:0] o_active_cnt, // Active cycles
  output logic [15:0] o_rise_cnt // Entries to active
);
  logic last;
  logic [15:0] left = 16'h0000;
  always @(posedge i_clock) begin
    o_done <= 1'b0;
    last <= i_line;
    if (i_start) begin
      left <= i_len;
      o_active_cnt <= 16'h0000;
      o_rise_cnt <= 16'h0000;
    end else if (left != 16'h0000) begin
      left <= left - 16'h0001;
      o_done <= (left == 16'h0001);
      o_active_cnt <= o_active_cnt + (i_line == i_active);
      o_rise_cnt <= o_rise_cnt + (i_line == i_active && last != i_active);
    end
  end
endmodule

/* File: tb/pwm_channel_init_and_duty_tb_top.sv */
// Self-checking bench for the PWM command block
`timescale 1ns/100ps
module pwm_channel_init_and_duty_tb_top;
  localparam logic [15:0] P0 = 16'h0028, P1 = 16'h0018;
  logic i_clock = 0, i_rst = 1, i_cmd_valid = 0, i_end_update = 0;
  logic i_phase_support = 0, ld_start = 0, ld_done;
  logic [7:0] i_cmd_id = 0, i_power_target = 0, i_cfg_ref = 0, o_power_state;
  logic [7:0] i_cfg_class = 8'h94;
  logic [1:0] i_cmd_channel = 0, sel = 0;
  logic [3:0] i_cfg_present = 4'h7, i_cfg_polarity = 4'h5, i_cfg_idle = 4'h6;
  logic [3:0] i_notify_en_set = 0, o_pwm, o_notify_en, o_edge_event;
  logic [15:0] i_cmd_duty = 0, d0, ld_len = 0, ld_act, ld_rise, dd[5];
  logic [63:0] i_cfg_period = 0, i_cfg_duty = 0, i_cfg_phase = 0;
  logic o_initialised, o_err_double_init, o_err_not_init, o_irq_en;
  logic [31:0] q_meas[$], q_err[$], rng = 32'd69;
  int n_errors = 0, checks = 0;
  always #12.5 i_clock = ~i_clock;
  pwmci_top pwmci_top_i (.*);
  pwmci_load pwmci_load_i (.i_clock(i_clock), .i_line(o_pwm[sel]),
    .i_active(i_cfg_polarity[sel]), .i_start(ld_start), .i_len(ld_len),
    .o_done(ld_done), .o_active_cnt(ld_act), .o_rise_cnt(ld_rise));
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic check(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic drain(input int lim);
    for (int k = 0; k < lim && q_meas.size() + q_err.size() > 0; k++)
      @(posedge i_clock);
    if (q_meas.size() + q_err.size() > 0) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic cmd(input logic [7:0] id, input logic [1:0] ch,
                     input logic [15:0] d, input logic [1:0] er);
    @(posedge i_clock);
    #2;
    if (er != 0) q_err.push_back({30'h0, er});
    i_cmd_valid = 1;
    i_cmd_id = id;
    i_cmd_channel = ch;
    i_cmd_duty = d;
    @(posedge i_clock);
    #2;
    i_cmd_valid = 0;
    drain(4);
  endtask
  task automatic meas(input logic [1:0] ch, input logic [15:0] p, d);
    logic [31:0] h;
    h = (p * ((d > 16'h8000) ? 32'h8000 : 32'(d))) >> 15;
    sel = ch;
    repeat (3 * p + 4) @(posedge i_clock);
    #2;
    q_meas.push_back({((h != 0 && h < p) ? 16'd4 : 16'd0), 16'(4 * h)});
    ld_len = 4 * p;
    ld_start = 1;
    @(posedge i_clock);
    #2;
    ld_start = 0;
    drain(4 * p + 8);
  endtask
  always @(posedge i_clock) begin
    if (ld_done === 1'b1) begin
      if (q_meas.size() == 0) check("window", 0, 1);
      else check("window", q_meas.pop_front(), {ld_rise, ld_act});
    end
    if (!i_rst && {o_err_double_init, o_err_not_init} !== 2'b00) begin
      if (q_err.size() == 0) check("error", 0, 1);
      else check("error", q_err.pop_front(),
        {30'h0, o_err_double_init, o_err_not_init});
    end
  end
  initial begin
    d0 = 16'(xs() % 32'h8001);
    i_cfg_period = {16'h0, 16'h0030, P1, P0};
    i_cfg_duty = {16'h0, 16'h8000, 16'h4000, d0};
    repeat (8) @(posedge i_clock);
    #2;
    i_rst = 0;
    check("reset", 0, {o_initialised, o_pwm});
    cmd(8'h02, 0, 16'h4000, 2'b01);
    cmd(8'h01, 0, 0, 2'b01);
    cmd(8'h00, 0, 0, 0);
    @(posedge i_clock);
    #2;
    check("init", 32'h3, {o_initialised, o_irq_en});
    meas(0, P0, d0);
    meas(1, P1, 16'h4000);
    cmd(8'h00, 0, 0, 2'b10);
    dd = '{16'h0000, 16'h8000, 16'hFFFF, 16'h2000, 16'(xs() % 32'h8001)};
    foreach (dd[k]) begin
      i_end_update = k[0];
      i_power_target = 8'(xs());
      cmd(8'h02, 0, dd[k], 0);
      meas(0, P0, dd[k]);
    end
    cmd(8'h02, 1, 16'h8000, 0);
    cmd(8'h02, 3, 16'h4000, 0);
    meas(0, P0, dd[4]);
    check("unused", 0, o_pwm[3]);
    @(posedge i_clock);
    #2;
    i_notify_en_set = 4'hF;
    @(posedge i_clock);
    #2;
    i_notify_en_set = 0;
    @(posedge i_clock);
    #2;
    check("notify", 32'hF, o_notify_en);
    cmd(8'h01, 0, 0, 0);
    repeat (3) @(posedge i_clock);
    #2;
    check("idle", i_cfg_idle & 4'h7, o_pwm & 4'h7);
    check("off", 0, {o_initialised, o_irq_en, o_notify_en});
    cmd(8'h00, 0, 0, 0);
    @(posedge i_clock);
    #2;
    check("reinit", 1, o_initialised);
    complete_run();
  end
endmodule
